/* File: lnkst_pkg.sv */
// Package for the link status and hold bit block
// Notes on behaviour
// - Four consecutive status words report state of up to 32 link units.
// - Bits 00 to 07 of each word are run flags of units.
// - Bits 08 to 15 of each word are error flags of units.
// - Single level: word 250 units 0-7 down to word 247 units 24-31.
// - Two level: words 250/249 level 0, words 248/247 level 1 units.
// - Program/monitor switch keeps forced bits if force hold bit is on.
// - Force hold works only after the configuration instruction enables it.
// - Force hold bit survives power loss unless an I/O table is registered.
// - Any switch into run returns all forced bits to default; a power restore in the same cycle with step-zero force hold on keeps them.
// - Step-zero configuration keeps force hold over power; forced bits kept if on.
// - Start or stop keeps I/O and link bits if I/O hold is on.
// - On one variant, I/O hold needs the configuration instruction enable.
// - I/O hold bit set by program output or by peripheral device.
// - Step-zero configuration keeps I/O hold over power; bits kept if on.
package lnkst_pkg;
  localparam int NUM_UNITS = 32;
  localparam int UNITS_PER_WORD = 8;
  // Printed word indices; byte address is four times the index
  localparam logic [11:0] IDX_STAT_HI = 12'h0f7;
  localparam logic [11:0] IDX_STAT_UMID = 12'h0f8;
  localparam logic [11:0] IDX_STAT_LMID = 12'h0f9;
  localparam logic [11:0] IDX_STAT_LOW = 12'h0fa;
  localparam logic [11:0] IDX_CTRL = 12'h100;
  localparam logic [11:0] IDX_EVENT = 12'h101;
  localparam logic [11:0] IDX_MASK = 12'h102;
  localparam logic [11:0] IDX_CFG = 12'h103;
  // Control word fields
  localparam int CTRL_FORCE_HOLD = 0;
  localparam int CTRL_IO_HOLD = 1;
  // Event word fields
  localparam int EV_UNIT_ERR = 0;
  localparam int EV_FORCE_CLR = 1;
  localparam int EV_IO_CLR = 2;
  localparam int EV_POWER = 3;
  localparam int EV_W = 4;
  localparam logic [EV_W-1:0] EV_RESET = 4'h0;
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
  typedef enum logic [1:0] {
    LNK_PROGRAM = 2'b00,
    LNK_MONITOR = 2'b01,
    LNK_RUN = 2'b11
  } lnkst_mode_t;
  typedef struct packed {
    logic forceEn;
    logic ioEn;
    logic atStep0;
  } lnkst_cfg_t;
  typedef struct packed {
    logic [NUM_UNITS-1:0] run;
    logic [NUM_UNITS-1:0] err;
  } lnkst_report_t;
endpackage

/* File: lnkst_regs.sv */
// Link status words, hold bits and their APB register file
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
module lnkst_regs import lnkst_pkg::*; #(
  parameter bit IO_HOLD_NEEDS_CFG = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Unit reports, index is level*16+unit in a two level network
  input wire lnkst_report_t unitReport,
  input wire logic scanTick,
  // Operating mode and events
  input wire lnkst_mode_t opMode,
  input wire logic powerRestore,
  input wire logic ioTableRegistered,
  input wire logic sysCfgExec,
  input wire lnkst_cfg_t sysCfg,
  input wire logic ioHoldSetProg,
  // Area control
  output logic forceClear,
  output logic ioClear,
  output logic forceHoldOut,
  output logic ioHoldOut,
  output logic irq
);

  logic [15:0] statWord_q [4];
  logic [NUM_UNITS-1:0] errPrev_q;
  logic forceHold_q, ioHold_q;
  logic forceEn_q, ioEn_q, cfgStep0_q;
  lnkst_mode_t mode_q;
  logic [EV_W-1:0] event_q, mask_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic forceClear_q, ioClear_q, irq_q;
  logic modeChg, toRun, progMon, startStop;
  logic forceKeep, ioKeep, errRise;
  logic apbWr, apbRd, apbDone;
  logic [11:0] regIdx;
  logic [EV_W-1:0] evSet;

  // Word select for a register index, -1 when not a status word
  function automatic int statSel(input logic [11:0] idx);
    case (idx)
      IDX_STAT_LOW: statSel = 0;
      IDX_STAT_LMID: statSel = 1;
      IDX_STAT_UMID: statSel = 2;
      IDX_STAT_HI: statSel = 3;
      default: statSel = -1;
    endcase
  endfunction

  assign regIdx = paddr[13:2];
  assign apbDone = psel && penable && pready_q;
  assign apbWr = apbDone && pwrite;
  assign apbRd = apbDone && !pwrite;

  // Mode transitions
  assign modeChg = opMode != mode_q;
  assign toRun = modeChg && opMode == LNK_RUN;
  assign progMon = modeChg && opMode != LNK_RUN && mode_q != LNK_RUN;
  assign startStop = modeChg;
  assign forceKeep = forceHold_q && forceEn_q;
  assign ioKeep = ioHold_q && (ioEn_q || !IO_HOLD_NEEDS_CFG);
  assign errRise = |(unitReport.err & ~errPrev_q) && scanTick;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mode_q <= LNK_PROGRAM;
    end else begin
      mode_q <= opMode;
    end
  end

  // Status words: unit n sits at bit n%8 of word n/8; word 0 is the highest index
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int w = 0; w < 4; w++) begin
        statWord_q[w] <= 16'h0000;
      end
      errPrev_q <= '0;
    end else if (scanTick) begin
      for (int w = 0; w < 4; w++) begin
        statWord_q[w][7:0] <= unitReport.run[w*UNITS_PER_WORD +: UNITS_PER_WORD];
        statWord_q[w][15:8] <= unitReport.err[w*UNITS_PER_WORD +: UNITS_PER_WORD];
      end
      errPrev_q <= unitReport.err;
    end
  end

  // Configuration instruction latches the hold enables
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      forceEn_q <= 1'b0;
      ioEn_q <= 1'b0;
      cfgStep0_q <= 1'b0;
    end else if (sysCfgExec) begin
      forceEn_q <= sysCfg.forceEn;
      ioEn_q <= sysCfg.ioEn;
      cfgStep0_q <= sysCfg.atStep0;
    end
  end

  // Force hold bit; software write is the peripheral path
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      forceHold_q <= 1'b0;
    end else if (powerRestore) begin
      // Lost unless configured at step zero or no table is registered
      forceHold_q <= forceHold_q && (cfgStep0_q || !ioTableRegistered);
    end else if (apbWr && regIdx == IDX_CTRL) begin
      forceHold_q <= pwdata[CTRL_FORCE_HOLD];
    end
  end

  // I/O hold bit; the program output instruction can only set it
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ioHold_q <= 1'b0;
    end else if (powerRestore) begin
      ioHold_q <= ioHold_q && cfgStep0_q;
    end else if (ioHoldSetProg) begin
      ioHold_q <= 1'b1;
    end else if (apbWr && regIdx == IDX_CTRL) begin
      ioHold_q <= pwdata[CTRL_IO_HOLD];
    end
  end

  // Area clear pulses, one cycle after their cause
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      forceClear_q <= 1'b0;
      ioClear_q <= 1'b0;
    end else begin
      if (powerRestore) begin
        forceClear_q <= !(forceHold_q && cfgStep0_q);
        ioClear_q <= !(ioHold_q && cfgStep0_q);
      end else begin
        forceClear_q <= toRun || (progMon && !forceKeep);
        ioClear_q <= startStop && !ioKeep;
      end
    end
  end

  // Sticky events; a set in the clearing read cycle wins
  always_comb begin
    evSet = '0;
    evSet[EV_UNIT_ERR] = errRise;
    evSet[EV_FORCE_CLR] = forceClear_q;
    evSet[EV_IO_CLR] = ioClear_q;
    evSet[EV_POWER] = powerRestore;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      event_q <= EV_RESET;
    end else if (apbRd && regIdx == IDX_EVENT) begin
      event_q <= evSet;
    end else begin
      event_q <= event_q | evSet;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mask_q <= MASK_RESET;
    end else if (apbWr && regIdx == IDX_MASK) begin
      mask_q <= pwdata[EV_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(event_q & mask_q);
    end
  end

  // APB: one wait-free access cycle; read data settled at setup
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready_q <= 1'b1;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      if (statSel(regIdx) >= 0) begin
        prdata_q <= {16'h0000, statWord_q[statSel(regIdx)]};
        pslverr_q <= pwrite;
      end else begin
        case (regIdx)
          IDX_CTRL: prdata_q <= {30'h0, ioHold_q, forceHold_q};
          IDX_EVENT: begin
            prdata_q <= {28'h0, event_q};
            pslverr_q <= pwrite;
          end
          IDX_MASK: prdata_q <= {28'h0, mask_q};
          IDX_CFG: begin
            prdata_q <= {29'h0, cfgStep0_q, ioEn_q, forceEn_q};
            pslverr_q <= pwrite;
          end
          default: pslverr_q <= 1'b1;
        endcase
      end
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Event bits can move between setup and access; return the live view
  assign prdata = (regIdx == IDX_EVENT) ? {28'h0, event_q} : prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign forceClear = forceClear_q;
  assign ioClear = ioClear_q;
  assign forceHoldOut = forceHold_q;
  assign ioHoldOut = ioHold_q;
  assign irq = irq_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_RUN_MAP: assert property (scanTick |=> statWord_q[0][7:0] == $past(unitReport.run[7:0]) && statWord_q[3][7:0] == $past(unitReport.run[31:24])) else $error("run flags misplaced");
  AST_ERR_MAP: assert property (scanTick |=> statWord_q[1][15:8] == $past(unitReport.err[15:8]) && statWord_q[2][15:8] == $past(unitReport.err[23:16])) else $error("error flags misplaced");
  AST_HOLD_STABLE: assert property (!scanTick |=> $stable(statWord_q[0]) && $stable(statWord_q[3])) else $error("status changed without scan");
  AST_RUN_CLEAR: assert property (toRun |=> forceClear) else $error("run entry kept forced bits");
  AST_FORCE_KEEP: assert property (progMon && !powerRestore && forceHold_q && forceEn_q |=> !forceClear) else $error("forced bits lost with hold");
  AST_FORCE_NOEN: assert property (progMon && !powerRestore && !forceEn_q |=> forceClear) else $error("hold applied without enable");
  AST_IO_CLEAR: assert property (modeChg && !powerRestore && !ioHold_q |=> ioClear) else $error("io area not reset");
  AST_IO_SET: assert property (ioHoldSetProg && !powerRestore |=> ioHoldOut) else $error("io hold not set");
  AST_PWR_FORCE: assert property (powerRestore && !cfgStep0_q && ioTableRegistered |=> !forceHoldOut ##0 forceClear) else $error("force hold kept over power");
  AST_PWR_IO: assert property (powerRestore && cfgStep0_q |=> ioHoldOut == $past(ioHold_q) ##0 ioClear == !$past(ioHold_q)) else $error("io hold power rule");
  AST_PWR_STEP0: assert property (powerRestore && cfgStep0_q && forceHold_q |=> forceHoldOut && !forceClear) else $error("forced state lost");
  AST_VARIANT: assert property (modeChg && !powerRestore && ioHold_q && !ioEn_q && IO_HOLD_NEEDS_CFG |=> ioClear) else $error("io hold without enable");
  AST_WORDS: assert property (apbDone && !pwrite && regIdx == IDX_STAT_LOW |-> prdata[31:16] == 16'h0000) else $error("status word upper bits set");
  AST_IRQ: assert property (evSet[EV_IO_CLR] && mask_q[EV_IO_CLR] ##1 !(apbRd && regIdx == IDX_EVENT) |=> irq) else $error("interrupt missing");
  CVR_RUN_ENTRY: cover property (toRun ##1 forceClear);
  CVR_HOLD_KEEP: cover property (progMon && forceKeep);
  CVR_POWER: cover property (powerRestore && cfgStep0_q && ioHold_q);
  CVR_IRQ: cover property (irq ##[1:4] apbRd && regIdx == IDX_EVENT);

endmodule // lnkst_regs

/* File: lnkst_unit_model.sv */
// Behavioural model of the networked link units feeding scan reports
`timescale 1ns/100ps
module lnkst_unit_model import lnkst_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Flags the bench asks the units to report
  input wire logic sendReq,
  input wire logic [NUM_UNITS-1:0] runSet,
  input wire logic [NUM_UNITS-1:0] errSet,
  // Report toward the block
  output lnkst_report_t unitReport,
  output logic scanTick
);
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      scanTick <= 1'b0;
      unitReport <= '0;
    end else if (sendReq) begin
      scanTick <= 1'b1;
      unitReport <= '{run: runSet, err: errSet};
    end else begin
      scanTick <= 1'b0;
      // Flags not valid between scans, so toggle them to catch stray sampling
      unitReport <= ~unitReport;
    end
  end
endmodule // lnkst_unit_model

/* File: lnkst_regs_test.sv */
// Self-checking bench for the link status and hold bit block
`timescale 1ns/100ps
module lnkst_regs_test import lnkst_pkg::*; ;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, er, scanTick, sendReq;
  logic powerRestore, ioTableRegistered, sysCfgExec, ioHoldSetProg, fcSeen, ioSeen;
  logic forceClear, ioClear, forceHoldOut, ioHoldOut, irq;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd, runSet, errSet;
  lnkst_report_t unitReport;
  lnkst_mode_t opMode;
  lnkst_cfg_t sysCfg;
  int fail_count, total_checks;

  lnkst_regs lnkst_regs_inst (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unitReport(unitReport), .scanTick(scanTick),
    .opMode(opMode), .powerRestore(powerRestore), .ioTableRegistered(ioTableRegistered),
    .sysCfgExec(sysCfgExec), .sysCfg(sysCfg), .ioHoldSetProg(ioHoldSetProg),
    .forceClear(forceClear), .ioClear(ioClear), .forceHoldOut(forceHoldOut),
    .ioHoldOut(ioHoldOut), .irq(irq));
  lnkst_unit_model lnkst_unit_model_inst (.core_clk(core_clk), .resetn(resetn),
    .sendReq(sendReq), .runSet(runSet), .errSet(errSet), .unitReport(unitReport),
    .scanTick(scanTick));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Pulses last one cycle, so latch them for the checks
  always @(posedge core_clk) begin
    if (forceClear === 1'b1) fcSeen <= 1'b1;
    if (ioClear === 1'b1) ioSeen <= 1'b1;
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string w);
    chk({31'h0, got}, {31'h0, exp}, w);
  endtask

  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // Look at the settled answer, then let the completing edge pass
    do begin
      @(negedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk(32'h0, 32'h1, "bus timeout");
      final_report();
    end
  endtask

  task automatic mode(input lnkst_mode_t m, input logic fc, input logic io);
    @(posedge core_clk);
    fcSeen = 1'b0;
    ioSeen = 1'b0;
    opMode <= m;
    repeat (4) @(posedge core_clk);
    chk1(fcSeen, fc, "forced clear");
    chk1(ioSeen, io, "area clear");
  endtask

  // Selector: 0 scan, 1 configuration, 2 power restore, 3 program hold set
  task automatic pulse(input int which);
    @(posedge core_clk);
    fcSeen = 1'b0;
    ioSeen = 1'b0;
    case (which)
      0: sendReq <= 1'b1;
      1: sysCfgExec <= 1'b1;
      2: powerRestore <= 1'b1;
      default: ioHoldSetProg <= 1'b1;
    endcase
    @(posedge core_clk);
    sendReq <= 1'b0;
    sysCfgExec <= 1'b0;
    powerRestore <= 1'b0;
    ioHoldSetProg <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic t_status();
    pulse(0);
    chk1(irq, 1'b0, "masked irq");
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, IDX_STAT_LOW - 12'(k), 32'h0);
      chk(rd, {16'h0, errSet[8*k+:8], runSet[8*k+:8]}, "status");
    end
    apb(1'b1, IDX_STAT_LOW, 32'hffff);
    chk1(er, 1'b1, "ro write");
    apb(1'b0, IDX_STAT_LOW, 32'h0);
    chk(rd, {16'h0, errSet[7:0], runSet[7:0]}, "word kept");
    apb(1'b0, 12'h0ff, 32'h0);
    chk1(er, 1'b1, "unmapped");
    $display("status test done");
  endtask

  task automatic t_irq();
    apb(1'b1, IDX_MASK, 32'h2);
    apb(1'b0, IDX_EVENT, 32'h0);
    chk(rd, 32'h1, "unit error event");
    mode(LNK_MONITOR, 1'b1, 1'b1);
    chk1(irq, 1'b1, "irq raised");
    apb(1'b0, IDX_EVENT, 32'h0);
    chk(rd, 32'h6, "events");
    repeat (3) @(posedge core_clk);
    chk1(irq, 1'b0, "irq cleared");
    $display("interrupt test done");
  endtask

  task automatic t_hold();
    apb(1'b1, IDX_CTRL, 32'h3);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk(rd, 32'h3, "ctrl");
    mode(LNK_PROGRAM, 1'b1, 1'b1);
    sysCfg <= '{forceEn: 1'b1, ioEn: 1'b1, atStep0: 1'b0};
    pulse(1);
    apb(1'b0, IDX_CFG, 32'h0);
    chk(rd, 32'h3, "cfg word");
    mode(LNK_MONITOR, 1'b0, 1'b0);
    mode(LNK_RUN, 1'b1, 1'b0);
    $display("hold test done");
  endtask

  task automatic t_power();
    ioTableRegistered <= 1'b1;
    pulse(2);
    chk1(fcSeen & ioSeen, 1'b1, "power clears");
    chk1(forceHoldOut | ioHoldOut, 1'b0, "holds dropped");
    pulse(3);
    chk1(ioHoldOut, 1'b1, "program sets hold");
    sysCfg <= '{forceEn: 1'b1, ioEn: 1'b1, atStep0: 1'b1};
    pulse(1);
    apb(1'b1, IDX_CTRL, 32'h3);
    pulse(2);
    chk1(fcSeen | ioSeen, 1'b0, "power keeps areas");
    chk1(forceHoldOut & ioHoldOut, 1'b1, "holds kept");
    $display("power test done");
  endtask

  initial begin
    {resetn, psel, penable, pwrite, sendReq, powerRestore} = '0;
    {ioTableRegistered, sysCfgExec, ioHoldSetProg, fcSeen, ioSeen} = '0;
    paddr = '0;
    pwdata = '0;
    opMode = LNK_PROGRAM;
    sysCfg = '0;
    runSet = 32'h3c5a96f0;
    errSet = 32'ha50f1e2d;
    fail_count = 0;
    total_checks = 0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    chk1(forceHoldOut | ioHoldOut | irq, 1'b0, "reset outputs");
    t_status();
    t_irq();
    t_hold();
    t_power();
    final_report();
  end
endmodule // lnkst_regs_test
